/* asc_speech_codec_ports.sv */
/*
 * Host parallel port, serial PCM port and mode control of a speech codec.
 * Host strobes and the serial clock are plain inputs sampled on clk; the
 * quantizer/predictor is replaced by a simple bit-slice stand-in.
 */
`timescale 1ns/10ps
`default_nettype none

// How it works
// - register select high status, low data
// - strobes count only with chip select
// - request reads in encoder, writes in decoder
// - no transfer request before a mode
// - status flag mirrors the pending request once running, set before
// - speech present when level exceeds threshold
// - command taken only while strobe active
// - command taken only while input enabled
// - serial input shifts only when enabled
// - serial output shifts only when enabled
// - output request when PCM sample ready
// - reset clears mode and state
// - one mode only, never both
// - encoder: serial PCM to host ADPCM
// - decoder: host ADPCM to serial PCM
// - two selectable bit rates
// - mu-law or linear PCM selectable
// - single system clock drives everything
// - data bus driven only during read
// - mode held until next reset
// - encoder takes two threshold bytes next
module asc_speech_codec_ports (
    input wire logic clk,
    input wire logic rst,
    input wire asc_pkg::asc_host_in_t hostIn,
    input wire asc_pkg::asc_ser_in_t serIn,
    output logic [7:0] hostDataOut,
    output logic hostDataOe,
    output logic transferRequest,
    output logic speechPresent,
    output logic serialOut,
    output logic serialOutRequest
);
    typedef enum logic [1:0] {
        ST_CMD,
        ST_TH_LO,
        ST_TH_HI,
        ST_RUN
    } asc_state_t;

    asc_state_t state_q;
    asc_pkg::asc_cmd_t cmd_q;
    asc_pkg::asc_mode_t mode_q;
    logic wrPrev_q, rdPrev_q, rdSel_q, sckPrev_q, strobePrev_q;
    logic [7:0] dataReg_q;
    logic [asc_pkg::THRESH_W-1:0] thresh_q;
    logic req_q, half_q;
    logic [3:0] pendCode_q;
    logic [asc_pkg::PCM_W-1:0] inShift_q, outShift_q;
    logic [asc_pkg::CNT_W-1:0] outCnt_q;
    logic [asc_pkg::ACC_W-1:0] acc_q;
    logic [asc_pkg::SPEECH_CNT_W-1:0] speechCnt_q;
    logic [7:0] hostDataOut_q;
    logic hostDataOe_q, speech_q, serialOut_q, outReq_q;

    // host strobe decode; both strobes low is the illegal case and does nothing
    logic wrAct, rdAct, wrStart, rdEnd, dataWr, dataRdDone;
    assign wrAct = !hostIn.csN && !hostIn.wrN && hostIn.rdN;
    assign rdAct = !hostIn.csN && !hostIn.rdN && hostIn.wrN;
    assign wrStart = wrAct && !wrPrev_q;
    assign rdEnd = !rdAct && rdPrev_q;
    assign dataWr = wrStart && !hostIn.registerSelect;
    assign dataRdDone = rdEnd && !rdSel_q;

    logic sckRise, sckFall, strobeRise, running, encRun, decRun;
    assign sckRise = serIn.serialClk && !sckPrev_q;
    assign sckFall = !serIn.serialClk && sckPrev_q;
    assign strobeRise = serIn.sampleStrobe && !strobePrev_q;
    assign running = (state_q == ST_RUN);
    assign encRun = running && (mode_q == asc_pkg::ASC_MODE_ENC);
    assign decRun = running && (mode_q == asc_pkg::ASC_MODE_DEC);

    logic cmdOk;
    assign cmdOk = (state_q == ST_CMD) && dataWr && serIn.sampleStrobe && serIn.serialInEnable;

    // status image: flag is set while commands/thresholds are awaited
    logic [7:0] statusVal;
    always_comb begin
        statusVal = 8'h00;
        statusVal[asc_pkg::STAT_REQ_BIT] = running ? req_q : 1'b1;
        statusVal[asc_pkg::STAT_SPEECH_BIT] = speech_q;
        statusVal[asc_pkg::STAT_ENC_BIT] = (mode_q == asc_pkg::ASC_MODE_ENC);
        statusVal[asc_pkg::STAT_DEC_BIT] = (mode_q == asc_pkg::ASC_MODE_DEC);
    end

    // sample conversion stand-ins
    logic [asc_pkg::PCM_W-1:0] pcmIn;
    logic [3:0] encCode, decNib;
    logic [asc_pkg::PCM_W-1:0] pcmOut;
    always_comb begin
        pcmIn = cmd_q.linear ? inShift_q : {inShift_q[asc_pkg::MULAW_W-1:0], 8'h00};
        encCode = cmd_q.lowRate ? {1'b0, pcmIn[15:13]} : pcmIn[15:12];
        decNib = half_q ? dataReg_q[3:0] : dataReg_q[7:4];
        pcmOut = cmd_q.lowRate ? {decNib[2:0], 13'h0000} : {decNib, 12'h000};
    end

    // edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPrev_q <= 1'b0;
            rdPrev_q <= 1'b0;
            rdSel_q <= 1'b0;
            sckPrev_q <= 1'b0;
            strobePrev_q <= 1'b0;
        end else begin
            wrPrev_q <= wrAct;
            rdPrev_q <= rdAct;
            if (rdAct) begin
                rdSel_q <= hostIn.registerSelect;
            end
            sckPrev_q <= serIn.serialClk;
            strobePrev_q <= serIn.sampleStrobe;
        end
    end

    // command and threshold sequencing; mode sticks until reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_CMD;
            cmd_q <= '0;
            mode_q <= asc_pkg::ASC_MODE_NONE;
            thresh_q <= '0;
        end else begin
            case (state_q)
                ST_CMD: begin
                    if (cmdOk) begin
                        cmd_q.encoder <= hostIn.data[asc_pkg::CMD_ENC_BIT];
                        cmd_q.lowRate <= hostIn.data[asc_pkg::CMD_LOWRATE_BIT];
                        cmd_q.linear <= hostIn.data[asc_pkg::CMD_LINEAR_BIT];
                        if (hostIn.data[asc_pkg::CMD_ENC_BIT]) begin
                            mode_q <= asc_pkg::ASC_MODE_ENC;
                            state_q <= ST_TH_LO;
                        end else begin
                            mode_q <= asc_pkg::ASC_MODE_DEC;
                            state_q <= ST_RUN;
                        end
                    end
                end
                ST_TH_LO: begin
                    if (dataWr) begin
                        thresh_q[7:0] <= hostIn.data;
                        state_q <= ST_TH_HI;
                    end
                end
                ST_TH_HI: begin
                    if (dataWr) begin
                        thresh_q[15:8] <= hostIn.data;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_CMD;
            endcase
        end
    end

    // transfer request: set wins over clear
    logic reqSet, reqClr;
    assign reqSet = (cmdOk && !hostIn.data[asc_pkg::CMD_ENC_BIT])
        || (encRun && strobeRise && half_q)
        || (decRun && strobeRise && half_q);
    assign reqClr = (encRun && dataRdDone) || (decRun && dataWr);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= reqSet || (req_q && !reqClr);
        end
    end
    assign transferRequest = req_q;

    // data register, half-byte tracking and encoder packing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataReg_q <= asc_pkg::DATA_RESET;
            half_q <= 1'b0;
            pendCode_q <= 4'h0;
        end else begin
            if (encRun && strobeRise) begin
                half_q <= !half_q;
                if (half_q) begin
                    dataReg_q <= {pendCode_q, encCode};
                end else begin
                    pendCode_q <= encCode;
                end
            end else if (decRun && strobeRise) begin
                half_q <= !half_q;
            end
            if (decRun && dataWr && req_q) begin
                dataReg_q <= hostIn.data;
            end
        end
    end

    // serial input capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inShift_q <= '0;
        end else if (sckRise && serIn.serialInEnable) begin
            inShift_q <= {inShift_q[asc_pkg::PCM_W-2:0], serIn.serialIn};
        end
    end

    // serial output: load on sample strobe, shift on falling clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outShift_q <= '0;
            outCnt_q <= '0;
            serialOut_q <= 1'b0;
            outReq_q <= 1'b0;
        end else begin
            if (decRun && strobeRise) begin
                outShift_q <= cmd_q.linear ? pcmOut : {pcmOut[15:8], 8'h00};
                outCnt_q <= cmd_q.linear ? asc_pkg::LINEAR_BITS : asc_pkg::MULAW_BITS;
                outReq_q <= 1'b1;
            end else if (sckFall && serIn.serialOutEnable && outCnt_q != '0) begin
                serialOut_q <= outShift_q[asc_pkg::PCM_W-1];
                outShift_q <= {outShift_q[asc_pkg::PCM_W-2:0], 1'b0};
                outCnt_q <= outCnt_q - 5'h01;
                if (outCnt_q == 5'h01) begin
                    outReq_q <= 1'b0;
                end
            end
        end
    end
    assign serialOut = serialOut_q;
    assign serialOutRequest = outReq_q;

    // speech detection over a window of sample magnitudes
    logic [asc_pkg::PCM_W-1:0] mag;
    logic [asc_pkg::ACC_W-1:0] accNext;
    always_comb begin
        mag = pcmIn[15] ? (~pcmIn + 16'h0001) : pcmIn;
        accNext = acc_q + {4'h0, mag};
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
            speechCnt_q <= '0;
            speech_q <= 1'b0;
        end else if (encRun && strobeRise) begin
            speechCnt_q <= speechCnt_q + 4'h1;
            if (speechCnt_q == 4'hf) begin
                acc_q <= '0;
                speech_q <= (accNext >> asc_pkg::SPEECH_SHIFT) > {4'h0, thresh_q};
            end else begin
                acc_q <= accNext;
            end
        end
    end
    assign speechPresent = speech_q;

    // host read data, driven only during a selected read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostDataOut_q <= 8'h00;
            hostDataOe_q <= 1'b0;
        end else begin
            hostDataOe_q <= rdAct;
            if (rdAct) begin
                hostDataOut_q <= hostIn.registerSelect ? statusVal : dataReg_q;
            end
        end
    end
    assign hostDataOut = hostDataOut_q;
    assign hostDataOe = hostDataOe_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence encSecondSample;
        encRun && strobeRise && half_q;
    endsequence
    sequence decSampleLoad;
        decRun && strobeRise;
    endsequence
    sequence decByteAccept;
        decRun && dataWr && transferRequest;
    endsequence
    sequence encByteRead;
        encRun && dataRdDone;
    endsequence

    a_request_idle: assert property (!running |-> !transferRequest)
        else $error("transfer request outside a mode");
    a_flag_mirror: assert property (rdAct && hostIn.registerSelect && running |=>
        hostDataOut[asc_pkg::STAT_REQ_BIT] == $past(transferRequest))
        else $error("status flag differs from request pin");
    a_status_select: assert property (rdAct && hostIn.registerSelect |=> hostDataOut == $past(statusVal))
        else $error("status read returned wrong value");
    a_bus_drive: assert property (hostDataOe == $past(rdAct))
        else $error("data bus driven outside a read");
    a_cmd_strobe: assert property (state_q == ST_CMD && dataWr && !serIn.sampleStrobe |=> state_q == ST_CMD)
        else $error("command taken without sample strobe");
    a_cmd_enable: assert property (state_q == ST_CMD && dataWr && !serIn.serialInEnable |=> state_q == ST_CMD)
        else $error("command taken without input enable");
    a_mode_hold: assert property (running |=> running && $stable(mode_q) && $stable(cmd_q))
        else $error("mode changed without reset");
    a_thresh_order: assert property (state_q == ST_TH_LO && dataWr |=> state_q == ST_TH_HI ##0 !running)
        else $error("threshold sequencing wrong");
    a_pack_request: assert property (encSecondSample |=> transferRequest && dataReg_q[3:0] == $past(encCode))
        else $error("packed byte not offered");
    a_outreq_load: assert property (decSampleLoad |=> serialOutRequest && outCnt_q != '0)
        else $error("output request missing after load");
    a_so_gate: assert property (!serIn.serialOutEnable && !(decRun && strobeRise) |=> $stable(outCnt_q))
        else $error("serial output shifted while disabled");
    a_si_gate: assert property (!serIn.serialInEnable |=> $stable(inShift_q))
        else $error("serial input shifted while disabled");
    a_dec_byte_load: assert property (decByteAccept |=> dataReg_q == $past(hostIn.data))
        else $error("written byte not loaded");
    a_dec_req_clear: assert property (decByteAccept ##0 !(strobeRise && half_q) |=> !transferRequest)
        else $error("decoder request not cleared by write");
    a_enc_req_clear: assert property (encByteRead ##0 !(strobeRise && half_q) |=> !transferRequest)
        else $error("encoder request not cleared by read");
    a_mode_valid: assert property (running |-> mode_q != asc_pkg::ASC_MODE_NONE)
        else $error("running without a mode");
    a_cmd_wait_idle: assert property (state_q == ST_CMD |->
        mode_q == asc_pkg::ASC_MODE_NONE && !transferRequest)
        else $error("mode or request left before command");
    a_speech_hold: assert property (!(encRun && strobeRise) |=> $stable(speechPresent))
        else $error("speech output changed between samples");
    a_si_capture: assert property (sckRise && serIn.serialInEnable |=> inShift_q[0] == $past(serIn.serialIn))
        else $error("serial input bit not captured");
    a_so_bit: assert property (sckFall && serIn.serialOutEnable && outCnt_q != '0 && !(decRun && strobeRise) |=>
        serialOut == $past(outShift_q[asc_pkg::PCM_W-1]))
        else $error("serial output bit wrong");
    a_outreq_end: assert property (sckFall && serIn.serialOutEnable && outCnt_q == 5'h01 && !(decRun && strobeRise) |=>
        !serialOutRequest)
        else $error("output request held after last bit");
    a_mu_count: assert property (decRun && strobeRise && !cmd_q.linear |=> outCnt_q == asc_pkg::MULAW_BITS)
        else $error("mu-law frame length wrong");
endmodule

`default_nettype wire

/* asc_pkg.sv */
/*
 * Shared constants and types for the speech codec host/serial port block.
 * Assumes one system clock; all pins are synchronous to it.
 */
`default_nettype none

package asc_pkg;
    // host side
    localparam int DATA_W = 8;
    localparam int CMD_ENC_BIT = 0;
    localparam int CMD_LOWRATE_BIT = 1;
    localparam int CMD_LINEAR_BIT = 2;
    localparam int STAT_REQ_BIT = 7;
    localparam int STAT_SPEECH_BIT = 5;
    localparam int STAT_ENC_BIT = 1;
    localparam int STAT_DEC_BIT = 0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // serial side
    localparam int PCM_W = 16;
    localparam int MULAW_W = 8;
    localparam int CNT_W = 5;
    localparam logic [4:0] LINEAR_BITS = 5'h10;
    localparam logic [4:0] MULAW_BITS = 5'h08;
    // coding
    localparam int CODE_HI_W = 4;
    localparam int CODE_LO_W = 3;
    localparam int THRESH_W = 16;
    localparam int SPEECH_WINDOW = 16;
    localparam int SPEECH_CNT_W = 4;
    localparam int SPEECH_SHIFT = 4;
    localparam int ACC_W = 20;
    // nominal system clock, for reference only
    localparam int SYS_CLK_NOMINAL_KHZ = 8192;

    typedef enum logic [1:0] {
        ASC_MODE_NONE,
        ASC_MODE_ENC,
        ASC_MODE_DEC
    } asc_mode_t;

    typedef struct packed {
        logic linear;
        logic lowRate;
        logic encoder;
    } asc_cmd_t;

    typedef struct packed {
        logic csN;
        logic registerSelect;
        logic wrN;
        logic rdN;
        logic [7:0] data;
    } asc_host_in_t;

    typedef struct packed {
        logic sampleStrobe;
        logic serialClk;
        logic serialInEnable;
        logic serialIn;
        logic serialOutEnable;
    } asc_ser_in_t;
endpackage

`default_nettype wire

/* asc_codec_model.sv */
/* Serial PCM converter stand-in: sample strobe, serial clock, data in/out.
   Assumes the bench calls its tasks; all changes land on falling clk edges. */
`timescale 1ns/10ps
`default_nettype none
module asc_codec_model (
    input wire logic clk,
    input wire logic serialOut,
    output logic sampleStrobe,
    output logic serialClk,
    output logic serialInEnable,
    output logic serialIn,
    output logic serialOutEnable
);
    logic [15:0] rxShift;
    initial begin
        sampleStrobe = 1'b0;
        serialClk = 1'b0;
        serialInEnable = 1'b0;
        serialIn = 1'b1;
        serialOutEnable = 1'b0;
        rxShift = 16'h0000;
    end
    task automatic arm(input logic s, input logic e);
        @(negedge clk);
        sampleStrobe = s;
        serialInEnable = e;
        serialOutEnable = e;
    endtask
    // n bits msb first, both enables tied; clock idles low between frames
    task automatic frame(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk);
            serialInEnable = 1'b1;
            serialOutEnable = 1'b1;
            serialIn = v[i];
            @(negedge clk);
            serialClk = 1'b1;
            @(negedge clk);
            serialClk = 1'b0;
            // output bit moves on the fall, so take it once settled
            @(negedge clk);
            rxShift = {rxShift[14:0], serialOut};
        end
        @(negedge clk);
        serialInEnable = 1'b0;
        serialOutEnable = 1'b0;
        serialIn = ~serialIn;
    endtask
    // one rising strobe per sample, held 8 cycles
    task automatic strobe();
        @(negedge clk);
        sampleStrobe = 1'b1;
        repeat (8) @(negedge clk);
        sampleStrobe = 1'b0;
    endtask
endmodule
`default_nettype wire

/* test_adpcm_speech_codec_ports.sv */
/* Self-checking bench for the speech codec host and serial ports.
   Assumes the codec model drives the serial side; host driven here. */
`timescale 1ns/10ps
`default_nettype none
module test_adpcm_speech_codec_ports;
    typedef struct packed {
        logic [7:0] exp;
        logic [7:0] mask;
    } asc_note_t;
    logic clk;
    logic rst;
    asc_pkg::asc_host_in_t hostIn;
    asc_pkg::asc_ser_in_t serIn;
    logic [7:0] hostDataOut;
    logic hostDataOe, transferRequest, speechPresent, serialOut, serialOutRequest;
    logic sStrobe, sClk, sInEn, sIn, sOutEn;
    asc_note_t notes[$];
    asc_note_t note;
    logic oePrev;
    int fail_count;
    int compares;
    integer seed;
    logic [7:0] rnd;

    asc_speech_codec_ports u_asc_speech_codec_ports (.clk(clk), .rst(rst), .hostIn(hostIn),
        .serIn(serIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .transferRequest(transferRequest), .speechPresent(speechPresent),
        .serialOut(serialOut), .serialOutRequest(serialOutRequest));
    asc_codec_model u_asc_codec_model (.clk(clk), .serialOut(serialOut), .sampleStrobe(sStrobe),
        .serialClk(sClk), .serialInEnable(sInEn), .serialIn(sIn), .serialOutEnable(sOutEn));
    assign serIn = {sStrobe, sClk, sInEn, sIn, sOutEn};

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic flag(input string name, input logic exp, input logic got);
        check(name, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        hostIn = '{csN: 1'b0, registerSelect: 1'b0, wrN: 1'b0, rdN: 1'b1, data: d};
        @(negedge clk);
        hostIn.wrN = 1'b1;
        hostIn.csN = 1'b1;
        @(negedge clk);
    endtask
    // expected value is noted only for a selected read
    task automatic rd(input logic rs, input logic [7:0] exp, input logic [7:0] mask, input logic cs);
        if (cs) notes.push_back(asc_note_t'{exp, mask});
        @(negedge clk);
        hostIn = '{csN: ~cs, registerSelect: rs, wrN: 1'b1, rdN: 1'b0, data: 8'h00};
        repeat (2) @(negedge clk);
        hostIn.rdN = 1'b1;
        hostIn.csN = 1'b1;
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        #1;
        if (hostDataOe === 1'b1 && oePrev !== 1'b1) begin
            if (notes.size() == 0) begin
                check("unrequested bus drive", 8'h00, 8'hff);
            end else begin
                note = notes.pop_front();
                check("hostDataOut", note.exp, hostDataOut & note.mask);
            end
        end
        oePrev = hostDataOe;
    end

    initial begin
        #200000;
        fail_count++;
        results();
    end

    initial begin
        seed = 89272;
        fail_count = 0;
        compares = 0;
        oePrev = 1'b0;
        hostIn = '{csN: 1'b1, registerSelect: 1'b0, wrN: 1'b1, rdN: 1'b1, data: 8'h00};
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd(1'b1, 8'h80, 8'hff, 1'b1);
        flag("transferRequest", 1'b0, transferRequest);
        u_asc_codec_model.arm(1'b0, 1'b1);
        wr(8'h00);
        u_asc_codec_model.arm(1'b1, 1'b0);
        wr(8'h00);
        rd(1'b1, 8'h80, 8'hff, 1'b1);
        flag("transferRequest", 1'b0, transferRequest);
        rd(1'b1, 8'h00, 8'h00, 1'b0);
        flag("hostDataOe", 1'b0, hostDataOe);
        // decoder, mu-law, high rate
        u_asc_codec_model.arm(1'b1, 1'b1);
        wr(8'h00);
        flag("transferRequest", 1'b1, transferRequest);
        rd(1'b1, 8'h81, 8'hff, 1'b1);
        rnd = 8'($random(seed));
        wr(rnd);
        flag("transferRequest", 1'b0, transferRequest);
        wr(8'h01);
        rd(1'b1, 8'h01, 8'hff, 1'b1);
        u_asc_codec_model.arm(1'b0, 1'b0);
        u_asc_codec_model.strobe();
        flag("serialOutRequest", 1'b1, serialOutRequest);
        u_asc_codec_model.frame(16'h0000, 8);
        flag("serialOutRequest", 1'b0, serialOutRequest);
        check("serialOut", {rnd[7:4], 4'h0}, u_asc_codec_model.rxShift[7:0]);
        // reset mid-run, then encoder, linear, low rate
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd(1'b1, 8'h80, 8'hff, 1'b1);
        u_asc_codec_model.arm(1'b1, 1'b1);
        wr(8'h07);
        rd(1'b1, 8'h82, 8'hff, 1'b1);
        wr(8'h10);
        wr(8'h00);
        rd(1'b1, 8'h02, 8'hff, 1'b1);
        u_asc_codec_model.arm(1'b0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            u_asc_codec_model.frame({2'b01, 14'($random(seed))}, 16);
            u_asc_codec_model.strobe();
            if (i == 1) begin
                flag("transferRequest", 1'b1, transferRequest);
                rd(1'b1, 8'h80, 8'h80, 1'b1);
                rd(1'b0, 8'h00, 8'h88, 1'b1);
                flag("transferRequest", 1'b0, transferRequest);
            end
        end
        flag("speechPresent", 1'b1, speechPresent);
        rd(1'b1, 8'h20, 8'h20, 1'b1);
        // reset again, then decoder, linear, low rate
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        u_asc_codec_model.arm(1'b1, 1'b1);
        wr(8'h06);
        rnd = 8'($random(seed));
        wr(rnd);
        u_asc_codec_model.arm(1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            u_asc_codec_model.strobe();
            flag("serialOutRequest", 1'b1, serialOutRequest);
            u_asc_codec_model.frame(16'h0000, 16);
            check("serialOut", {(i == 0) ? rnd[6:4] : rnd[2:0], 5'h00}, u_asc_codec_model.rxShift[15:8]);
        end
        flag("transferRequest", 1'b1, transferRequest);
        results();
    end
endmodule
`default_nettype wire
